// >>> logic/eirq_pin_sense.sv
/*
 * one sense slice for pin a or pin b: two-stage sampler, edge compare
 * and the low-level term.
 * assumes the pin is synchronous to mclk and io_run marks the io clock.
 */
`default_nettype none
module eirq_pin_sense (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // slice side of the carrier
    eirq_sense_if.slice sif
);
    typedef struct packed {
        logic smp1;
        logic smp2;
        logic prev;
        logic primed;
    } eirq_slice_s;

    eirq_slice_s st;
    eirq_slice_s next_st;

    // sample chain; frozen while the io clock is halted
    always_comb begin
        next_st = st;
        // first cycle after reset loads the pin everywhere: no false edge
        if (!st.primed) begin
            next_st.primed = 1'b1;
            next_st.smp1 = sif.pin;
            next_st.smp2 = sif.pin;
            next_st.prev = sif.pin;
        end else if (sif.io_run) begin
            next_st.smp1 = sif.pin;
            next_st.smp2 = st.smp1;
            next_st.prev = st.smp2;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // edge decode on the sampled copies only
    always_comb begin
        sif.hit = 1'b0;
        if (sif.io_run && st.primed) begin
            case (sif.sense)
                eirq_pkg::SENSE_ANY: sif.hit = st.smp2 ^ st.prev;
                eirq_pkg::SENSE_FALL: sif.hit = st.prev & ~st.smp2;
                eirq_pkg::SENSE_RISE: sif.hit = ~st.prev & st.smp2;
                default: sif.hit = 1'b0;
            endcase
        end
    end

    assign sif.level_low = ~sif.pin;
endmodule
`default_nettype wire

// >>> logic/eirq_top.sv
/*
 * external pin interrupts: control, enable and flag registers, sense
 * logic for pins a, b and c, requests to the core and wake-up.
 * assumes pins, strobes and sleep controls are synchronous to mclk,
 * wdt_tick is one-cycle pulse per watchdog oscillator period.
 */
// Function
// - pins trigger even when driven as outputs
// - pin c is edge only, no level
// - level mode requests while pin stays low
// - pin a/b edges need running io clock
// - a/b level and c edge need no io clock
// - level wake needs two low watchdog samples
// - level gone before start-up: wake, no request
// - pin b sense field bits 3:2 encoding
// - pin a sense field bits 1:0 encoding
// - a/b sampled before edges, longer pulses caught
// - control-status bit 6 picks pin c edge
// - pin c pulses over 50 ns are caught
// - request needs enable bit and global enable
// - each pin has its own request line
// - flags bits 7,6,5 set on trigger
// - flags clear on vector taken or write one
// - a/b flags read zero in level mode
// - pin c buffer off may set its flag
`default_nettype none
module eirq_top (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // register port
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // interrupt pins
    input wire logic ext_irq_pin_a,
    input wire logic ext_irq_pin_b,
    input wire logic ext_irq_pin_c,
    // core side
    input wire logic glob_irq_en,
    input wire logic [2:0] irq_taken,
    output logic irq_req_a,
    output logic irq_req_b,
    output logic irq_req_c,
    // sleep and wake
    input wire logic io_clk_run,
    input wire logic deep_sleep,
    input wire logic pin_c_buf_off,
    input wire logic wdt_tick,
    input wire logic startup_done,
    output logic wake_req,
    output logic wake_no_irq
);
    localparam int FILT_W = $clog2(eirq_pkg::PIN_C_FILT_CYC + 1);

    typedef struct packed {
        logic [7:0] cpu_control;
        logic sense_c_edge;
        logic [2:0] enable;
        logic [2:0] flag;
        logic c_stable;
        logic c_primed;
        logic [FILT_W-1:0] c_cnt;
        logic [1:0] wdt_cnt;
        logic waking;
        logic wake_req;
        logic wake_no_irq;
        logic [7:0] rdata;
    } eirq_state_s;

    eirq_state_s st;
    eirq_state_s next_st;

    eirq_sense_if sif_a ();
    eirq_sense_if sif_b ();

    logic [1:0] sense_a;
    logic [1:0] sense_b;
    logic lvl_a;
    logic lvl_b;
    logic c_in;
    logic c_edge;
    logic c_hit;
    logic any_low;
    logic [2:0] hit;
    logic [2:0] w1c;
    logic [7:0] rd_val;

    assign sense_a = st.cpu_control[eirq_pkg::SENSE_A_LO +: 2];
    assign sense_b = st.cpu_control[eirq_pkg::SENSE_B_LO +: 2];
    assign lvl_a = (sense_a == eirq_pkg::SENSE_LOW);
    assign lvl_b = (sense_b == eirq_pkg::SENSE_LOW);

    // raw pad level, port direction ignored
    assign sif_a.pin = ext_irq_pin_a;
    assign sif_b.pin = ext_irq_pin_b;
    assign sif_a.sense = sense_a;
    assign sif_b.sense = sense_b;
    assign sif_a.io_run = io_clk_run;
    assign sif_b.io_run = io_clk_run;

    eirq_pin_sense u_sense_a (
        .mclk(mclk),
        .rst_b(rst_b),
        .sif(sif_a.slice)
    );

    eirq_pin_sense u_sense_b (
        .mclk(mclk),
        .rst_b(rst_b),
        .sif(sif_b.slice)
    );

    assign c_in = pin_c_buf_off ? 1'b0 : ext_irq_pin_c;
    // accept after half the least width
    assign c_edge = st.c_primed && (c_in != st.c_stable)
                    && (st.c_cnt == FILT_W'(eirq_pkg::PIN_C_FILT_CYC - 1));
    // pick edge, registered without io clock
    assign c_hit = c_edge && (c_in == st.sense_c_edge);

    // pin c has no level term
    assign hit = {c_hit, sif_a.hit, sif_b.hit};

    // write-one-to-clear mask from the flag register
    assign w1c = (reg_wr && reg_addr == eirq_pkg::OFS_EXT_IRQ_FLAGS)
                 ? {reg_wdata[eirq_pkg::BIT_PIN_C], reg_wdata[eirq_pkg::BIT_PIN_A],
                    reg_wdata[eirq_pkg::BIT_PIN_B]}
                 : 3'h0;

    // level low on any enabled level-mode pin
    assign any_low = (st.enable[1] && lvl_a && sif_a.level_low)
                     || (st.enable[0] && lvl_b && sif_b.level_low);

    // read mux; unused bits read as zero
    always_comb begin
        rd_val = 8'h00;
        case (reg_addr)
            eirq_pkg::OFS_CPU_CONTROL: rd_val = st.cpu_control;
            eirq_pkg::OFS_CPU_CONTROL_STATUS: rd_val[eirq_pkg::SENSE_C_EDGE] = st.sense_c_edge;
            eirq_pkg::OFS_EXT_IRQ_ENABLE: begin
                rd_val[eirq_pkg::BIT_PIN_C] = st.enable[2];
                rd_val[eirq_pkg::BIT_PIN_A] = st.enable[1];
                rd_val[eirq_pkg::BIT_PIN_B] = st.enable[0];
            end
            eirq_pkg::OFS_EXT_IRQ_FLAGS: begin
                rd_val[eirq_pkg::BIT_PIN_C] = st.flag[2];
                rd_val[eirq_pkg::BIT_PIN_A] = st.flag[1] && !lvl_a;
                rd_val[eirq_pkg::BIT_PIN_B] = st.flag[0] && !lvl_b;
            end
            default: rd_val = 8'h00;
        endcase
    end

    // next state
    always_comb begin
        next_st = st;
        next_st.wake_req = 1'b0;
        next_st.wake_no_irq = 1'b0;
        // data only in the cycle after the read strobe
        next_st.rdata = reg_rd ? rd_val : 8'h00;

        // register writes
        if (reg_wr) begin
            case (reg_addr)
                eirq_pkg::OFS_CPU_CONTROL: next_st.cpu_control = reg_wdata;
                eirq_pkg::OFS_CPU_CONTROL_STATUS: begin
                    // no guard; the change alone cannot raise a flag, only a filtered pin c edge does
                    next_st.sense_c_edge = reg_wdata[eirq_pkg::SENSE_C_EDGE];
                end
                eirq_pkg::OFS_EXT_IRQ_ENABLE: begin
                    next_st.enable = {reg_wdata[eirq_pkg::BIT_PIN_C],
                                      reg_wdata[eirq_pkg::BIT_PIN_A],
                                      reg_wdata[eirq_pkg::BIT_PIN_B]};
                end
                default: next_st.enable = st.enable;
            endcase
        end

        // clear on vector or write one
        next_st.flag = (st.flag & ~(w1c | irq_taken)) | hit;
        // level mode keeps a/b flags clear
        if (lvl_a) begin
            next_st.flag[1] = 1'b0;
        end
        if (lvl_b) begin
            next_st.flag[0] = 1'b0;
        end

        // pin c stability counter
        if (c_in == st.c_stable || c_edge) begin
            next_st.c_cnt = '0;
        end else begin
            next_st.c_cnt = st.c_cnt + FILT_W'(1);
        end
        if (c_edge) begin
            next_st.c_stable = c_in;
        end
        // idle-high pin after reset would look like an edge; take it as stable
        if (!st.c_primed) begin
            next_st.c_primed = 1'b1;
            next_st.c_stable = c_in;
            next_st.c_cnt = '0;
        end

        // two watchdog samples of the level
        if (!deep_sleep) begin
            next_st.wdt_cnt = 2'h0;
        end else if (wdt_tick) begin
            if (!any_low) begin
                next_st.wdt_cnt = 2'h0;
            end else if (st.wdt_cnt != eirq_pkg::WAKE_SAMPLES) begin
                next_st.wdt_cnt = st.wdt_cnt + 2'h1;
            end
        end
        if (deep_sleep && !st.waking
            && (st.wdt_cnt == eirq_pkg::WAKE_SAMPLES || (c_hit && st.enable[2]))) begin
            next_st.wake_req = 1'b1;
            next_st.waking = 1'b1;
        end
        if (st.waking && startup_done) begin
            next_st.waking = 1'b0;
            next_st.wdt_cnt = 2'h0;
            next_st.wake_no_irq = !any_low && (st.flag[2] == 1'b0);
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            st <= '0;
            st.cpu_control <= eirq_pkg::RST_CPU_CONTROL;
            st.rdata <= eirq_pkg::RST_BYTE;
        end else begin
            st <= next_st;
        end
    end

    // level request while pin is low
    // held level needed by the core
    assign irq_req_a = glob_irq_en && st.enable[1]
                       && (lvl_a ? sif_a.level_low : st.flag[1]);
    assign irq_req_b = glob_irq_en && st.enable[0]
                       && (lvl_b ? sif_b.level_low : st.flag[0]);
    assign irq_req_c = glob_irq_en && st.enable[2] && st.flag[2];

    assign reg_rdata = st.rdata;
    assign wake_req = st.wake_req;
    assign wake_no_irq = st.wake_no_irq;
endmodule
`default_nettype wire

// >>> pkg/eirq_pkg.sv
/*
 * constants for the external pin interrupt block: register offsets,
 * bit positions, reset values, sense encodings and timing counts.
 * assumes a 200 MHz mclk and an 8-bit register port.
 */
`default_nettype none
package eirq_pkg;
    // register offsets on the plain register port
    localparam logic [1:0] OFS_CPU_CONTROL = 2'h0;
    localparam logic [1:0] OFS_CPU_CONTROL_STATUS = 2'h1;
    localparam logic [1:0] OFS_EXT_IRQ_ENABLE = 2'h2;
    localparam logic [1:0] OFS_EXT_IRQ_FLAGS = 2'h3;
    // reset values
    localparam logic [7:0] RST_CPU_CONTROL = 8'h00;
    localparam logic [7:0] RST_BYTE = 8'h00;
    // field positions
    localparam int SENSE_A_LO = 0;
    localparam int SENSE_B_LO = 2;
    localparam int SENSE_C_EDGE = 6;
    localparam int BIT_PIN_B = 7;
    localparam int BIT_PIN_A = 6;
    localparam int BIT_PIN_C = 5;
    // sense encodings for pins a and b
    localparam logic [1:0] SENSE_LOW = 2'h0;
    localparam logic [1:0] SENSE_ANY = 2'h1;
    localparam logic [1:0] SENSE_FALL = 2'h2;
    localparam logic [1:0] SENSE_RISE = 2'h3;
    // timing: pin c least pulse width and clock period
    localparam int CLK_PERIOD_NS = 5;
    localparam int PIN_C_PULSE_NS = 50;
    localparam int PIN_C_PULSE_CYC = (PIN_C_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PIN_C_FILT_CYC = PIN_C_PULSE_CYC / 2;
    // watchdog samples needed for a level wake-up
    localparam logic [1:0] WAKE_SAMPLES = 2'h2;
endpackage
`default_nettype wire

// >>> pkg/eirq_sense_if.sv
/*
 * carrier between the top and one edge/level sense slice.
 * assumes both ends sit in the mclk domain.
 */
`default_nettype none
interface eirq_sense_if;
    logic pin;
    logic [1:0] sense;
    logic io_run;
    logic hit;
    logic level_low;
    modport ctrl (output pin, output sense, output io_run, input hit, input level_low);
    modport slice (input pin, input sense, input io_run, output hit, output level_low);
endinterface
`default_nettype wire

// >>> verification/eirq_pin_src.sv
/* source model for the three pins, idle high.
   assumes the bench calls its tasks; changes follow an mclk edge. */
`default_nettype none
module eirq_pin_src (
    // clock
    input wire logic mclk,
    // pins: [0] a, [1] b, [2] c
    output var logic [2:0] pins
);
    timeunit 1ns;
    timeprecision 1ps;
    initial pins = 3'h7;
    // one level change just after an edge
    task drive(input int p, input logic v);
        @(posedge mclk);
        pins[p] <= v;
    endtask
    // low held past the current instruction
    task hold_low(input int p, input int n);
        drive(p, 1'b0);
        repeat (n) @(posedge mclk);
        pins[p] <= 1'b1;
    endtask
endmodule
`default_nettype wire

// >>> verification/eirq_props.sv
/* port checker for eirq_top.
   assumes a bind onto eirq_top, one mclk domain. */
`default_nettype none
module eirq_props (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // register writes
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    // pins and core side
    input wire logic ext_irq_pin_a,
    input wire logic ext_irq_pin_b,
    input wire logic glob_irq_en,
    input wire logic io_clk_run,
    input wire logic startup_done,
    input wire logic irq_req_a,
    input wire logic irq_req_b,
    input wire logic irq_req_c,
    input wire logic wake_req,
    input wire logic wake_no_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] ctl;
    logic [7:0] ena;
    // shadow of control and enable, same write timing as the design
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ctl <= 8'h00;
            ena <= 8'h00;
        end else if (reg_wr) begin
            if (reg_addr == eirq_pkg::OFS_CPU_CONTROL) ctl <= reg_wdata;
            if (reg_addr == eirq_pkg::OFS_EXT_IRQ_ENABLE) ena <= reg_wdata;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    property p_lvl_a;
        glob_irq_en && ena[6] && ctl[1:0] == eirq_pkg::SENSE_LOW && !ext_irq_pin_a |-> irq_req_a;
    endproperty
    a_lvl_a: assert property (p_lvl_a) else $error("level a no request");
    property p_lvl_b;
        glob_irq_en && ena[7] && ctl[3:2] == eirq_pkg::SENSE_LOW && !ext_irq_pin_b |-> irq_req_b;
    endproperty
    a_lvl_b: assert property (p_lvl_b) else $error("level b no request");
    property p_en_a;
        irq_req_a |-> glob_irq_en && ena[6];
    endproperty
    a_en_a: assert property (p_en_a) else $error("request a not enabled");
    property p_en_b;
        irq_req_b |-> glob_irq_en && ena[7];
    endproperty
    a_en_b: assert property (p_en_b) else $error("request b not enabled");
    property p_en_c;
        irq_req_c |-> glob_irq_en && ena[5];
    endproperty
    a_en_c: assert property (p_en_c) else $error("request c not enabled");
    // sampled falling edge reaches request in bounded time
    property p_fall_a;
        $fell(ext_irq_pin_a) && ctl[1:0] == eirq_pkg::SENSE_FALL && ena[6] && glob_irq_en
            && io_clk_run |-> ##[1:4] irq_req_a;
    endproperty
    a_fall_a: assert property (p_fall_a) else $error("fall a missed");
    // no new edge request while io clock is stopped
    property p_stop_a;
        (!io_clk_run && !irq_req_a && ctl[1:0] != eirq_pkg::SENSE_LOW) [*3] |=> !irq_req_a;
    endproperty
    a_stop_a: assert property (p_stop_a) else $error("edge seen without io clock");
    // wake is a single pulse out of sleep
    property p_wake;
        wake_req |-> ##1 !wake_req;
    endproperty
    a_wake: assert property (p_wake) else $error("wake pulse too long");
    // no-request wake only after start-up end
    property p_no_irq;
        wake_no_irq |-> $past(startup_done);
    endproperty
    a_no_irq: assert property (p_no_irq) else $error("early no-request wake");
endmodule
`default_nettype wire

// >>> verification/eirq_test.sv
/* bench for eirq_top: register tasks and pin sequences.
   assumes eirq_props and eirq_pin_src compiled before it. */
`default_nettype none
module eirq_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic [1:0] reg_addr = 2'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic glob_irq_en = 1'b1;
    logic [2:0] irq_taken = 3'h0;
    logic io_clk_run = 1'b1;
    logic deep_sleep = 1'b0;
    logic wdt_tick = 1'b0;
    logic startup_done = 1'b0;
    logic pin_c_buf_off = 1'b0;
    logic [7:0] reg_rdata;
    logic [2:0] pins;
    logic [2:0] req;
    logic wake_req;
    logic wake_no_irq;
    int failures = 0;
    int n_checks = 0;
    int fbit[3] = '{6, 7, 5};
    int tbit[3] = '{1, 0, 2};
    // 200 MHz
    always #2.5 mclk = ~mclk;
    eirq_pin_src eirq_pin_src_i (.mclk, .pins);
    eirq_top eirq_top_i (.mclk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .ext_irq_pin_a(pins[0]), .ext_irq_pin_b(pins[1]), .ext_irq_pin_c(pins[2]),
        .glob_irq_en, .irq_taken, .irq_req_a(req[0]), .irq_req_b(req[1]),
        .irq_req_c(req[2]), .io_clk_run, .deep_sleep, .pin_c_buf_off, .wdt_tick,
        .startup_done, .wake_req, .wake_no_irq);
    // bus and helper tasks
    task idle(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task chk(input string n, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %s exp %h got %h", n, e, g);
        end
    endtask
    task wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [1:0] a, input logic [7:0] e);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        chk("reg", e, reg_rdata);
    endtask
    task tick;
        @(posedge mclk);
        wdt_tick <= 1'b1;
        @(posedge mclk);
        wdt_tick <= 1'b0;
    endtask
    // bounded wait on a wake output
    task wait_out(input logic nirq);
        int i;
        for (i = 0; i < 20; i++) begin
            #1;
            if ((nirq ? wake_no_irq : wake_req) === 1'b1) break;
            @(posedge mclk);
        end
        chk("wake", 8'h00, (i == 20) ? 8'h01 : 8'h00);
        if (i == 20) finish_test();
    endtask
    // one sense: first flag cleared by the vector, second by a write
    task edge_test(input int p, input logic [1:0] m);
        logic [7:0] fm;
        fm = 8'h01 << fbit[p];
        wr(eirq_pkg::OFS_EXT_IRQ_ENABLE, 8'h00);
        if (p == 2) wr(eirq_pkg::OFS_CPU_CONTROL_STATUS, {1'b0, m[0], 6'h00});
        else wr(eirq_pkg::OFS_CPU_CONTROL, {4'h0, m, m});
        wr(eirq_pkg::OFS_EXT_IRQ_FLAGS, 8'he0);
        wr(eirq_pkg::OFS_EXT_IRQ_ENABLE, fm);
        eirq_pin_src_i.drive(p, 1'b0);
        idle(12);
        rd(eirq_pkg::OFS_EXT_IRQ_FLAGS, (m != eirq_pkg::SENSE_RISE) ? fm : 8'h00);
        chk("req", {7'h00, m != eirq_pkg::SENSE_RISE}, {7'h00, req[p]});
        @(posedge mclk);
        irq_taken[tbit[p]] <= 1'b1;
        @(posedge mclk);
        irq_taken <= 3'h0;
        eirq_pin_src_i.drive(p, 1'b1);
        idle(12);
        rd(eirq_pkg::OFS_EXT_IRQ_FLAGS, (m != eirq_pkg::SENSE_FALL) ? fm : 8'h00);
        @(posedge mclk);
        glob_irq_en <= 1'b0;
        @(posedge mclk);
        #1;
        chk("req off", 8'h00, {7'h00, req[p]});
        @(posedge mclk);
        glob_irq_en <= 1'b1;
        wr(eirq_pkg::OFS_EXT_IRQ_FLAGS, fm);
        rd(eirq_pkg::OFS_EXT_IRQ_FLAGS, 8'h00);
    endtask
    // verdict, the only exit
    task finish_test;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // main sequence
    initial begin
        idle(5);
        rst_b <= 1'b1;
        idle(12);
        for (int a = 0; a < 4; a++) rd(2'(a), a == 0 ? eirq_pkg::RST_CPU_CONTROL : eirq_pkg::RST_BYTE);
        wr(eirq_pkg::OFS_CPU_CONTROL_STATUS, 8'hff);
        rd(eirq_pkg::OFS_CPU_CONTROL_STATUS, 8'h40);
        $display("test regs done");
        for (int p = 0; p < 3; p++) begin
            for (int m = 1; m < 4; m++) begin
                if (p < 2 || m > 1) edge_test(p, 2'(m));
            end
        end
        $display("test edges done");
        wr(eirq_pkg::OFS_CPU_CONTROL, 8'h00);
        wr(eirq_pkg::OFS_EXT_IRQ_ENABLE, 8'hc0);
        fork
            eirq_pin_src_i.hold_low(0, 8);
            begin
                idle(4);
                #1;
                chk("lvl req", 8'h01, {7'h00, req[0]});
                rd(eirq_pkg::OFS_EXT_IRQ_FLAGS, 8'h00);
            end
        join
        idle(2);
        #1;
        chk("lvl end", 8'h00, {7'h00, req[0]});
        $display("test level done");
        wr(eirq_pkg::OFS_CPU_CONTROL, 8'h0a);
        wr(eirq_pkg::OFS_CPU_CONTROL_STATUS, 8'h00);
        wr(eirq_pkg::OFS_EXT_IRQ_FLAGS, 8'he0);
        @(posedge mclk);
        io_clk_run <= 1'b0;
        eirq_pin_src_i.drive(0, 1'b0);
        eirq_pin_src_i.drive(2, 1'b0);
        idle(12);
        rd(eirq_pkg::OFS_EXT_IRQ_FLAGS, 8'h20);
        eirq_pin_src_i.drive(0, 1'b1);
        eirq_pin_src_i.drive(2, 1'b1);
        @(posedge mclk);
        io_clk_run <= 1'b1;
        idle(8);
        rd(eirq_pkg::OFS_EXT_IRQ_FLAGS, 8'h20);
        $display("test io stop done");
        // buffer off with pin c high and disabled looks like a falling edge
        wr(eirq_pkg::OFS_EXT_IRQ_FLAGS, 8'he0);
        pin_c_buf_off <= 1'b1;
        idle(12);
        rd(eirq_pkg::OFS_EXT_IRQ_FLAGS, 8'h20);
        @(posedge mclk);
        pin_c_buf_off <= 1'b0;
        idle(12);
        wr(eirq_pkg::OFS_EXT_IRQ_FLAGS, 8'he0);
        rd(eirq_pkg::OFS_EXT_IRQ_FLAGS, 8'h00);
        $display("test buffer off done");
        wr(eirq_pkg::OFS_CPU_CONTROL, 8'h00);
        wr(eirq_pkg::OFS_EXT_IRQ_ENABLE, 8'h40);
        @(posedge mclk);
        deep_sleep <= 1'b1;
        io_clk_run <= 1'b0;
        eirq_pin_src_i.drive(0, 1'b0);
        tick();
        tick();
        wait_out(1'b0);
        eirq_pin_src_i.drive(0, 1'b1);
        @(posedge mclk);
        startup_done <= 1'b1;
        @(posedge mclk);
        startup_done <= 1'b0;
        wait_out(1'b1);
        $display("test wake done");
        finish_test();
    end
endmodule
bind eirq_top eirq_props eirq_props_i (.mclk, .rst_b, .reg_addr, .reg_wdata, .reg_wr,
    .ext_irq_pin_a, .ext_irq_pin_b, .glob_irq_en, .io_clk_run, .startup_done,
    .irq_req_a, .irq_req_b, .irq_req_c, .wake_req, .wake_no_irq);
`default_nettype wire
